// file: hdl/limit_check.sv
// Compares the upper bits of a result against an upper and a lower limit
`timescale 1ns/1ps
module limit_check #(
  parameter int W  = 10,
  parameter int LW = 8
) (
  input  wire logic                 signed_in,
  input  wire logic [W-1:0]         value_in,
  input  wire mon_pkg::limit_pair_t limits_in,
  output logic                      out_of_limit_out
);
  logic [LW-1:0] top;
  logic          above;
  logic          below;

  assign top = value_in[W-1 -: LW];

  always_comb begin
    if (signed_in) begin
      above = $signed(top) > $signed(limits_in.hi);
      below = $signed(top) <= $signed(limits_in.lo);
    end else begin
      above = top > limits_in.hi;
      below = top <= limits_in.lo;
    end
    out_of_limit_out = above || below;
  end
endmodule

// file: hdl/measurement_sequencer_limit_monitor.sv
// Measurement sequencer, result registers and limit monitor
// What this block does
// - After reset: cyclic mode selected, conversions disabled.
// - Conversion enable bit starts measuring; cleared means no conversion.
// - Cyclic order: supply, internal temp, external temp or inputs, input 3, input 4.
// - After input 4 the cycle wraps to supply by itself.
// - Single-channel bit at 0x19 stops cycling, converts the selected channel only.
// - Selection zero is supply, selection one is internal temperature.
// - Single-channel conversions follow back to back with no gap.
// - Serial access aborts the conversion; it resumes when access ends.
// - Internal temperature offset register is added before storing.
// - Temperature results are 10-bit twos complement.
// - Sixteen raw temperature samples are averaged per stored result.
// - One temperature step is a quarter degree.
// - Negative temperature codes follow twos complement, minus forty is 0x360.
// - Flag when result is above upper limit or at or below lower limit.
// - Limits are 8 bits, results are 10 bits.
// - Unmasked out-of-limit results set flags in registers 0x00 and 0x01.
// - Any active flag drives the interrupt pin to the chosen polarity.
// - Reference amplifier powered only while monitoring is enabled.
// - Supply and temperature conversions always use the internal reference.
// - Supply low bits go to 0x03, upper bits to 0x06.
// - Reading a low-bits register freezes its upper-bits registers until one is read.
`timescale 1ns/1ps
module measurement_sequencer_limit_monitor (
  input  wire logic       CLOCK_IN,
  input  wire logic       RST_IN,
  input  wire logic [7:0] REG_ADDR_IN,
  input  wire logic [7:0] REG_WDATA_IN,
  input  wire logic       REG_WR_IN,
  input  wire logic       REG_RD_IN,
  output logic      [7:0] REG_RDATA_OUT,
  input  wire logic       SERIAL_BUSY_IN,
  output logic            CONV_START_OUT,
  output logic      [2:0] CONV_CHANNEL_OUT,
  output logic            USE_INT_REF_OUT,
  output logic            REF_AMP_ON_OUT,
  input  wire logic       CONV_DONE_IN,
  input  wire logic [9:0] CONV_DATA_IN,
  output logic            INT_OUT
);
  // ****************************************************
  // Declarations
  // ****************************************************
  mon_pkg::seq_state_t  state;
  mon_pkg::seq_state_t  next_state;
  logic [2:0]           cur_ch;
  logic [2:0]           next_ch;
  logic [2:0]           sel_ch;
  logic [9:0]           raw;
  logic [9:0]           next_raw;
  logic [9:0]           store_val;
  logic [9:0]           avg_mean;
  logic                 start;
  logic                 next_start;
  logic                 int_ref;
  logic                 next_int_ref;
  logic                 amp_on;
  logic                 avg_add;
  logic                 avg_clear;
  logic                 avg_last;
  logic                 avg_active;
  logic                 is_temp;
  logic                 conv_en;
  logic                 single;
  logic                 ain12;
  logic                 oor;
  logic                 store;
  mon_pkg::limit_pair_t cur_lim;
  logic [7:0]           ctrl1, ctrl2, ctrl3, mask1, mask2, ofs_int, ofs_ext;
  logic [7:0]           next_ctrl1, next_ctrl2, next_ctrl3;
  logic [7:0]           next_mask1, next_mask2, next_ofs_int, next_ofs_ext;
  logic [7:0]           lim_hi [mon_pkg::NUM_CH];
  logic [7:0]           lim_lo [mon_pkg::NUM_CH];
  logic [7:0]           next_lim_hi [mon_pkg::NUM_CH];
  logic [7:0]           next_lim_lo [mon_pkg::NUM_CH];
  logic [7:0]           msb_val [mon_pkg::NUM_CH];
  logic [7:0]           next_msb_val [mon_pkg::NUM_CH];
  logic [1:0]           lsb_val [mon_pkg::NUM_CH];
  logic [1:0]           next_lsb_val [mon_pkg::NUM_CH];
  logic [5:0]           flags, next_flags, live, next_live, mask_vec;
  logic                 lock_a, lock_b, next_lock_a, next_lock_b;
  logic [7:0]           rdata, next_rdata;
  logic                 irq, next_irq;
  logic                 rd_msb_a, rd_msb_b;

  assign REG_RDATA_OUT    = rdata;
  assign CONV_START_OUT   = start;
  assign CONV_CHANNEL_OUT = cur_ch;
  assign USE_INT_REF_OUT  = int_ref;
  assign REF_AMP_ON_OUT   = amp_on;
  assign INT_OUT          = irq;

  // ****************************************************
  // Decoded controls
  // ****************************************************
  assign conv_en    = ctrl1[mon_pkg::C1_CONV_EN];
  assign ain12      = ctrl1[mon_pkg::C1_AIN12];
  assign single     = ctrl2[mon_pkg::C2_SINGLE];
  assign sel_ch     = (ctrl2[2:0] > mon_pkg::CH_AIN4) ? mon_pkg::CH_VDD : ctrl2[2:0];
  assign is_temp    = (cur_ch == mon_pkg::CH_INT) || (cur_ch == mon_pkg::CH_EXT && !ain12);
  assign avg_active = is_temp && !ctrl2[mon_pkg::C2_AVG_OFF];
  assign store      = (state == mon_pkg::ST_STORE);
  assign mask_vec   = {mask1[4:0], mask2[0]};
  assign cur_lim    = '{hi: lim_hi[cur_ch], lo: lim_lo[cur_ch]};

  // Offset added before storing the temperature result
  always_comb begin
    store_val = raw;
    if (cur_ch == mon_pkg::CH_INT) begin
      store_val = raw + {{2{ofs_int[7]}}, ofs_int};
    end else if (is_temp) begin
      store_val = raw + {{2{ofs_ext[7]}}, ofs_ext};
    end
  end

  sample_averager #(.W(mon_pkg::VAL_W), .LOG_N(mon_pkg::AVG_LOG)) u_avg (
    .clk_in    (CLOCK_IN),
    .rst_in    (RST_IN),
    .clear_in  (avg_clear),
    .add_in    (avg_add),
    .sample_in (CONV_DATA_IN),
    .last_out  (avg_last),
    .mean_out  (avg_mean)
  );

  limit_check #(.W(mon_pkg::VAL_W), .LW(mon_pkg::LIM_W)) u_lim (
    .signed_in        (is_temp),
    .value_in         (store_val),
    .limits_in        (cur_lim),
    .out_of_limit_out (oor)
  );

  // ****************************************************
  // Sequencer
  // ****************************************************
  always_comb begin
    next_state = state;
    next_ch    = cur_ch;
    next_raw   = raw;
    avg_add    = 1'b0;
    avg_clear  = 1'b0;
    case (state)
      mon_pkg::ST_IDLE: begin
        avg_clear = 1'b1;
        if (single) next_ch = sel_ch;
        next_state = mon_pkg::ST_START;
      end
      mon_pkg::ST_START: next_state = mon_pkg::ST_WAIT;
      mon_pkg::ST_WAIT: begin
        if (CONV_DONE_IN) begin
          avg_add    = avg_active;
          next_raw   = avg_active ? avg_mean : CONV_DATA_IN;
          next_state = (avg_active && !avg_last) ? mon_pkg::ST_START : mon_pkg::ST_STORE;
        end
      end
      mon_pkg::ST_STORE: begin
        avg_clear  = 1'b1;
        next_state = mon_pkg::ST_START;
        if (single) begin
          next_ch = sel_ch;
        end else begin
          case (cur_ch)
            mon_pkg::CH_VDD:  next_ch = mon_pkg::CH_INT;
            mon_pkg::CH_INT:  next_ch = mon_pkg::CH_EXT;
            mon_pkg::CH_EXT:  next_ch = ain12 ? mon_pkg::CH_AIN2 : mon_pkg::CH_AIN3;
            mon_pkg::CH_AIN2: next_ch = mon_pkg::CH_AIN3;
            mon_pkg::CH_AIN3: next_ch = mon_pkg::CH_AIN4;
            default:          next_ch = mon_pkg::CH_VDD;
          endcase
        end
      end
      default: next_state = mon_pkg::ST_IDLE;
    endcase
    if (!conv_en || SERIAL_BUSY_IN) next_state = mon_pkg::ST_IDLE;
    next_start   = (next_state == mon_pkg::ST_START);
    next_int_ref = (next_ch <= mon_pkg::CH_EXT) || !ctrl3[mon_pkg::C3_INPUT_EXTREF];
  end

  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state   <= mon_pkg::ST_IDLE;
      cur_ch  <= mon_pkg::CH_VDD;
      raw     <= '0;
      start   <= 1'b0;
      int_ref <= 1'b1;
      amp_on  <= 1'b0;
    end else begin
      state   <= next_state;
      cur_ch  <= next_ch;
      raw     <= next_raw;
      start   <= next_start;
      int_ref <= next_int_ref;
      amp_on  <= conv_en;
    end
  end

  // ****************************************************
  // Register file
  // ****************************************************
  assign rd_msb_a = REG_RD_IN && (REG_ADDR_IN == mon_pkg::A_MSB_VDD
                    || REG_ADDR_IN == mon_pkg::A_MSB_VDD + 8'h01);
  assign rd_msb_b = REG_RD_IN && (REG_ADDR_IN >= mon_pkg::A_MSB_VDD + 8'h02)
                    && (REG_ADDR_IN <= mon_pkg::A_MSB_VDD + 8'h05);

  always_comb begin
    next_ctrl1   = ctrl1;
    next_ctrl2   = ctrl2;
    next_ctrl3   = ctrl3;
    next_mask1   = mask1;
    next_mask2   = mask2;
    next_ofs_int = ofs_int;
    next_ofs_ext = ofs_ext;
    next_lim_hi  = lim_hi;
    next_lim_lo  = lim_lo;
    next_msb_val = msb_val;
    next_lsb_val = lsb_val;
    next_flags   = flags;
    next_live    = live;
    next_rdata   = rdata;
    next_lock_a  = lock_a;
    next_lock_b  = lock_b;
    if (REG_WR_IN) begin
      case (REG_ADDR_IN)
        mon_pkg::A_CTRL1:   next_ctrl1 = REG_WDATA_IN;
        mon_pkg::A_CTRL2:   next_ctrl2 = REG_WDATA_IN;
        mon_pkg::A_CTRL3:   next_ctrl3 = REG_WDATA_IN;
        mon_pkg::A_MASK1:   next_mask1 = REG_WDATA_IN;
        mon_pkg::A_MASK2:   next_mask2 = REG_WDATA_IN;
        mon_pkg::A_OFS_INT: next_ofs_int = REG_WDATA_IN;
        mon_pkg::A_OFS_EXT: next_ofs_ext = REG_WDATA_IN;
        default:            next_ctrl1 = ctrl1;
      endcase
      for (int i = 0; i < mon_pkg::NUM_CH; i++) begin
        if (REG_ADDR_IN == mon_pkg::LIM_BASE[i]) next_lim_hi[i] = REG_WDATA_IN;
        if (REG_ADDR_IN == mon_pkg::LIM_BASE[i] + 8'h01) next_lim_lo[i] = REG_WDATA_IN;
      end
    end
    if (REG_RD_IN) begin
      next_rdata = mon_pkg::REG_RST;
      case (REG_ADDR_IN)
        mon_pkg::A_FLAGS1: begin
          next_rdata = {3'h0, flags[5:1]};
          next_flags[5:1] = flags[5:1] & live[5:1];
        end
        mon_pkg::A_FLAGS2: begin
          next_rdata = {7'h00, flags[0]};
          next_flags[0] = flags[0] & live[0];
        end
        mon_pkg::A_LSB_A: begin
          next_rdata = {4'h0, lsb_val[1], lsb_val[0]};
          next_lock_a = 1'b1;
        end
        mon_pkg::A_LSB_B: begin
          next_rdata = {lsb_val[5], lsb_val[4], lsb_val[3], lsb_val[2]};
          next_lock_b = 1'b1;
        end
        mon_pkg::A_CTRL1:   next_rdata = ctrl1;
        mon_pkg::A_CTRL2:   next_rdata = ctrl2;
        mon_pkg::A_CTRL3:   next_rdata = ctrl3;
        mon_pkg::A_MASK1:   next_rdata = mask1;
        mon_pkg::A_MASK2:   next_rdata = mask2;
        mon_pkg::A_OFS_INT: next_rdata = ofs_int;
        mon_pkg::A_OFS_EXT: next_rdata = ofs_ext;
        default:            next_rdata = mon_pkg::REG_RST;
      endcase
      for (int i = 0; i < mon_pkg::NUM_CH; i++) begin
        if (REG_ADDR_IN == mon_pkg::A_MSB_VDD + 8'(i)) next_rdata = msb_val[i];
        if (REG_ADDR_IN == mon_pkg::LIM_BASE[i]) next_rdata = lim_hi[i];
        if (REG_ADDR_IN == mon_pkg::LIM_BASE[i] + 8'h01) next_rdata = lim_lo[i];
      end
      if (rd_msb_a) next_lock_a = 1'b0;
      if (rd_msb_b) next_lock_b = 1'b0;
    end
    if (store) begin
      next_lsb_val[cur_ch] = store_val[1:0];
      if (!((cur_ch <= mon_pkg::CH_INT) ? lock_a : lock_b)) begin
        next_msb_val[cur_ch] = store_val[9:2];
      end
      next_live[cur_ch] = oor;
      if (oor && !mask_vec[cur_ch]) next_flags[cur_ch] = 1'b1;
    end
    next_irq = (|flags) ? ctrl1[mon_pkg::C1_POL] : !ctrl1[mon_pkg::C1_POL];
  end

  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ctrl1   <= mon_pkg::REG_RST;
      ctrl2   <= mon_pkg::REG_RST;
      ctrl3   <= mon_pkg::REG_RST;
      mask1   <= mon_pkg::REG_RST;
      mask2   <= mon_pkg::REG_RST;
      ofs_int <= mon_pkg::REG_RST;
      ofs_ext <= mon_pkg::REG_RST;
      for (int i = 0; i < mon_pkg::NUM_CH; i++) begin
        lim_hi[i]  <= mon_pkg::LIM_HI_RST[i];
        lim_lo[i]  <= mon_pkg::LIM_LO_RST[i];
        msb_val[i] <= mon_pkg::REG_RST;
        lsb_val[i] <= 2'h0;
      end
      flags  <= '0;
      live   <= '0;
      rdata  <= mon_pkg::REG_RST;
      lock_a <= 1'b0;
      lock_b <= 1'b0;
      irq    <= 1'b0;
    end else begin
      ctrl1   <= next_ctrl1;
      ctrl2   <= next_ctrl2;
      ctrl3   <= next_ctrl3;
      mask1   <= next_mask1;
      mask2   <= next_mask2;
      ofs_int <= next_ofs_int;
      ofs_ext <= next_ofs_ext;
      lim_hi  <= next_lim_hi;
      lim_lo  <= next_lim_lo;
      msb_val <= next_msb_val;
      lsb_val <= next_lsb_val;
      flags   <= next_flags;
      live    <= next_live;
      rdata   <= next_rdata;
      lock_a  <= next_lock_a;
      lock_b  <= next_lock_b;
      irq     <= next_irq;
    end
  end

  // ****************************************************
  // Checks
  // ****************************************************
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (RST_IN);

  sequence s_store_rr(logic [2:0] ch);
    store && !single && cur_ch == ch && conv_en && !SERIAL_BUSY_IN;
  endsequence

  a_idle_when_off: assert property (!conv_en |=> state == mon_pkg::ST_IDLE && !start)
    else $error("Conversion activity while disabled");
  a_order_vdd_int: assert property (s_store_rr(mon_pkg::CH_VDD)
    |=> cur_ch == mon_pkg::CH_INT)
    else $error("Cyclic order broken after supply");
  a_wrap_to_vdd: assert property (s_store_rr(mon_pkg::CH_AIN4)
    |=> start && cur_ch == mon_pkg::CH_VDD)
    else $error("Cycle did not wrap to supply");
  a_single_channel: assert property (store && single |=> cur_ch == $past(sel_ch))
    else $error("Single mode picked wrong channel");
  a_back_to_back: assert property (store && conv_en && !SERIAL_BUSY_IN
    |=> start ##1 (state == mon_pkg::ST_WAIT || $past(!conv_en || SERIAL_BUSY_IN)))
    else $error("Gap between conversions");
  a_busy_abort: assert property (SERIAL_BUSY_IN |=> state == mon_pkg::ST_IDLE && !start)
    else $error("Conversion not aborted by serial access");
  a_flag_sets: assert property (store && oor && !mask_vec[cur_ch] |=> flags[$past(cur_ch)])
    else $error("Out-of-limit flag not set");
  a_int_level: assert property (!$past(RST_IN)
    |-> INT_OUT == ($past(|flags) ? $past(ctrl1[mon_pkg::C1_POL])
                                  : !$past(ctrl1[mon_pkg::C1_POL])))
    else $error("Interrupt level wrong");
  a_amp_follows: assert property ($rose(conv_en)
    |=> REF_AMP_ON_OUT ##0 $past(REF_AMP_ON_OUT) == 1'b0)
    else $error("Reference amplifier not following enable");
  a_int_ref_used: assert property (start && cur_ch <= mon_pkg::CH_EXT |-> USE_INT_REF_OUT)
    else $error("External reference on supply or temperature");
  a_msb_frozen: assert property (lock_a && !rd_msb_a
    |=> $stable(msb_val[0]) && $stable(msb_val[1]))
    else $error("Locked upper bits changed");
endmodule

// file: hdl/sample_averager.sv
// Running sum of signed samples, yields the mean of each group of 2**LOG_N
`timescale 1ns/1ps
module sample_averager #(
  parameter int W     = 10,
  parameter int LOG_N = 4
) (
  input  wire logic                clk_in,
  input  wire logic                rst_in,
  input  wire logic                clear_in,
  input  wire logic                add_in,
  input  wire logic signed [W-1:0] sample_in,
  output logic                     last_out,
  output logic [W-1:0]             mean_out
);
  logic signed [W+LOG_N-1:0] sum;
  logic signed [W+LOG_N-1:0] next_sum;
  logic signed [W+LOG_N-1:0] total;
  logic [LOG_N-1:0]          cnt;
  logic [LOG_N-1:0]          next_cnt;

  assign last_out = &cnt;
  assign mean_out = total[W+LOG_N-1:LOG_N];

  always_comb begin
    total    = sum + (W+LOG_N)'(sample_in);
    next_sum = sum;
    next_cnt = cnt;
    if (clear_in || (add_in && last_out)) begin
      next_sum = '0;
      next_cnt = '0;
    end else if (add_in) begin
      next_sum = total;
      next_cnt = cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sum <= '0;
      cnt <= '0;
    end else begin
      sum <= next_sum;
      cnt <= next_cnt;
    end
  end
endmodule

// file: inc/mon_pkg.sv
// Shared constants and types for the measurement sequencer and limit monitor
package mon_pkg;
  // ****************************************************
  // Widths and counts
  // ****************************************************
  localparam int VAL_W   = 10;
  localparam int LIM_W   = 8;
  localparam int NUM_CH  = 6;
  localparam int AVG_LOG = 4;

  // ****************************************************
  // Register addresses
  // ****************************************************
  localparam logic [7:0] A_FLAGS1  = 8'h00;
  localparam logic [7:0] A_FLAGS2  = 8'h01;
  localparam logic [7:0] A_LSB_A   = 8'h03;
  localparam logic [7:0] A_LSB_B   = 8'h04;
  localparam logic [7:0] A_MSB_VDD = 8'h06;
  localparam logic [7:0] A_CTRL1   = 8'h18;
  localparam logic [7:0] A_CTRL2   = 8'h19;
  localparam logic [7:0] A_CTRL3   = 8'h1A;
  localparam logic [7:0] A_MASK1   = 8'h1D;
  localparam logic [7:0] A_MASK2   = 8'h1E;
  localparam logic [7:0] A_OFS_INT = 8'h1F;
  localparam logic [7:0] A_OFS_EXT = 8'h20;
  // Upper limit at base, lower limit at base plus one
  localparam logic [7:0] LIM_BASE   [NUM_CH] = '{8'h23, 8'h25, 8'h27, 8'h2B, 8'h2D, 8'h2F};
  localparam logic [7:0] LIM_HI_RST [NUM_CH] = '{8'hC7, 8'h64, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  localparam logic [7:0] LIM_LO_RST [NUM_CH] = '{8'h62, 8'hC9, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] REG_RST    = 8'h00;

  // ****************************************************
  // Control bit positions
  // ****************************************************
  localparam int C1_CONV_EN   = 0;
  localparam int C1_AIN12     = 2;
  localparam int C1_POL       = 3;
  localparam int C2_SINGLE    = 4;
  localparam int C2_AVG_OFF   = 5;
  localparam int C3_INPUT_EXTREF = 4;

  // ****************************************************
  // Channels
  // ****************************************************
  localparam logic [2:0] CH_VDD  = 3'h0;
  localparam logic [2:0] CH_INT  = 3'h1;
  localparam logic [2:0] CH_EXT  = 3'h2;
  localparam logic [2:0] CH_AIN2 = 3'h3;
  localparam logic [2:0] CH_AIN3 = 3'h4;
  localparam logic [2:0] CH_AIN4 = 3'h5;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_START = 4'h2,
    ST_WAIT  = 4'h4,
    ST_STORE = 4'h8
  } seq_state_t;

  typedef struct packed {
    logic [LIM_W-1:0] hi;
    logic [LIM_W-1:0] lo;
  } limit_pair_t;
endpackage

// file: test/conv_model.sv
// Behavioural converter that answers start pulses with a result after a delay
`timescale 1ns/1ps
module conv_model (
  input  wire logic       clk_in,
  input  wire logic       start_in,
  input  wire logic [2:0] ch_in,
  input  wire logic       wobble_in,
  input  wire logic       slow_in,
  output logic            done_out,
  output logic      [9:0] data_out
);
  // ****************************************************
  // Conversion results and timing
  // ****************************************************
  int         cnt = 0;
  logic       odd = 1'b0;
  logic [9:0] res;

  initial begin
    done_out = 1'b0;
    data_out = 10'h155;
  end

  always_comb begin
    case (ch_in)
      3'h0:    res = 10'h2DD;
      3'h1:    res = 10'h360 + ((wobble_in && odd) ? 10'h008 : 10'h000);
      3'h2:    res = 10'h040;
      3'h4:    res = 10'h3FC;
      3'h5:    res = 10'h200;
      default: res = 10'h111;
    endcase
  end

  // Data line toggles outside the done cycle so nothing stale is read
  always @(posedge clk_in) begin
    done_out <= 1'b0;
    data_out <= ~data_out;
    if (start_in) begin
      cnt <= slow_in ? 14 : 3;
    end else if (cnt == 1) begin
      done_out <= 1'b1;
      data_out <= res;
      odd      <= ~odd;
      cnt      <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule

// file: test/test_measurement_sequencer_limit_monitor.sv
// Self-checking bench for the measurement sequencer and limit monitor
`timescale 1ns/1ps
module test_measurement_sequencer_limit_monitor;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       busy = 1'b0;
  logic       wobble = 1'b0;
  logic       slow = 1'b0;
  logic [7:0] rdata;
  logic       start;
  logic [2:0] ch;
  logic       int_ref;
  logic       amp;
  logic       done;
  logic [9:0] cdata;
  logic       intr;
  logic [2:0] c;
  logic [2:0] rr [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h0};
  int         num_errors = 0;
  int         num_checks = 0;
  int         nstart = 0;
  int         k;

  always #5 clk = ~clk;

  always @(posedge clk) begin
    if (start) begin
      nstart <= nstart + 1;
    end
  end

  measurement_sequencer_limit_monitor DUT (
    .CLOCK_IN         (clk),
    .RST_IN           (rst),
    .REG_ADDR_IN      (addr),
    .REG_WDATA_IN     (wdata),
    .REG_WR_IN        (wr),
    .REG_RD_IN        (rd),
    .REG_RDATA_OUT    (rdata),
    .SERIAL_BUSY_IN   (busy),
    .CONV_START_OUT   (start),
    .CONV_CHANNEL_OUT (ch),
    .USE_INT_REF_OUT  (int_ref),
    .REF_AMP_ON_OUT   (amp),
    .CONV_DONE_IN     (done),
    .CONV_DATA_IN     (cdata),
    .INT_OUT          (intr)
  );

  conv_model model (
    .clk_in    (clk),
    .start_in  (start),
    .ch_in     (ch),
    .wobble_in (wobble),
    .slow_in   (slow),
    .done_out  (done),
    .data_out  (cdata)
  );

  // ****************************************************
  // Tasks
  // ****************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("errors=%0d checks=%0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask

  task automatic check_rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    check(16'(rdata), 16'(exp));
  endtask

  task automatic next_start(output logic [2:0] cs);
    int n;
    n = 0;
    @(negedge clk);
    while (start !== 1'b1) begin
      n++;
      if (n > 300) begin
        num_errors++;
        end_of_test();
      end
      @(negedge clk);
    end
    cs = ch;
  endtask

  // ****************************************************
  // Sequence
  // ****************************************************
  initial begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    k = nstart;
    repeat (20) @(negedge clk);
    check(16'(nstart - k), 16'h0);
    check(16'(amp), 16'h0);
    check_rd(8'h19, 8'h00);
    check_rd(8'h02, 8'h00);
    wr_reg(8'h1F, 8'h04);
    wr_reg(8'h1D, 8'h04);
    wr_reg(8'h1A, 8'h10);
    wr_reg(8'h27, 8'h10);
    wr_reg(8'h2D, 8'h10);
    wr_reg(8'h30, 8'h80);
    wr_reg(8'h19, 8'h20);
    wr_reg(8'h18, 8'h01);
    foreach (rr[i]) begin
      next_start(c);
      check(16'(c), 16'(rr[i]));
      check(16'(int_ref), 16'(c < 3'h3));
    end
    check(16'(amp), 16'h1);
    check_rd(8'h03, 8'h01);
    check_rd(8'h06, 8'hB7);
    check_rd(8'h07, 8'hD9);
    check_rd(8'h00, 8'h18);
    check_rd(8'h01, 8'h00);
    check(16'(intr), 16'h0);
    wr_reg(8'h18, 8'h09);
    repeat (3) @(negedge clk);
    check(16'(intr), 16'h1);
    wr_reg(8'h19, 8'h30);
    next_start(c);
    for (k = 0; k < 3; k++) begin
      next_start(c);
      check(16'(c), 16'h0);
    end
    slow = 1'b1;
    for (k = 0; k < 300 && done !== 1'b1; k++) begin
      @(negedge clk);
    end
    if (done !== 1'b1) begin
      num_errors++;
      end_of_test();
    end
    for (k = 0; k < 9 && (k == 0 || start !== 1'b1); k++) begin
      @(negedge clk);
    end
    check(16'(k), 16'h2);
    wr_reg(8'h19, 8'h31);
    next_start(c);
    next_start(c);
    check(16'(c), 16'h1);
    busy = 1'b1;
    repeat (2) @(negedge clk);
    k = nstart;
    repeat (40) @(negedge clk);
    check(16'(nstart - k), 16'h0);
    busy = 1'b0;
    next_start(c);
    check(16'(c), 16'h1);
    slow = 1'b0;
    wobble = 1'b1;
    wr_reg(8'h19, 8'h11);
    repeat (48) next_start(c);
    check_rd(8'h07, 8'hDA);
    wr_reg(8'h18, 8'h0D);
    wr_reg(8'h19, 8'h20);
    for (k = 0; k < 8 && c !== 3'h0; k++) begin
      next_start(c);
    end
    check(16'(c), 16'h0);
    for (k = 1; k < 6; k++) begin
      next_start(c);
      check(16'(c), 16'(k));
      check(16'(int_ref), 16'(k < 3));
    end
    wr_reg(8'h18, 8'h00);
    repeat (3) @(negedge clk);
    k = nstart;
    repeat (40) @(negedge clk);
    check(16'(nstart - k), 16'h0);
    check(16'(amp), 16'h0);
    end_of_test();
  end
endmodule
